// >>> logic/itr_pkg.sv
package itr_pkg;

	// ------------------------------------------------------------
	// Sizes and timing
	// ------------------------------------------------------------
	localparam int          NUM_TERM       = 5;
	localparam int          CODE_W         = 14;
	localparam int          CLK_HZ         = 20000000;
	localparam int          FAST_TIME_US   = 2000;
	localparam int          SLOW_TIME_US   = 20000;
	localparam int          FILTER_TIME_US = 10000;
	localparam int          FAST_CYC       = FAST_TIME_US * (CLK_HZ / 1000000);
	localparam int          SLOW_CYC       = SLOW_TIME_US * (CLK_HZ / 1000000);
	localparam int          FILTER_CYC     = FILTER_TIME_US * (CLK_HZ / 1000000);
	localparam int          SYNC_CYC       = 3;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0]  OFS_FWD_SEL    = 8'h00;
	localparam logic [7:0]  OFS_REV_SEL    = 8'h04;
	localparam logic [7:0]  OFS_LOW_SEL    = 8'h08;
	localparam logic [7:0]  OFS_MID_SEL    = 8'h0c;
	localparam logic [7:0]  OFS_HIGH_SEL   = 8'h10;
	localparam logic [7:0]  OFS_POLARITY   = 8'h14;
	localparam logic [7:0]  OFS_REMOTE     = 8'h18;
	localparam logic [7:0]  OFS_OPMODE     = 8'h1c;
	localparam logic [7:0]  OFS_CTRL       = 8'h20;
	localparam logic [7:0]  OFS_FUNC_STAT  = 8'h24;
	localparam logic [7:0]  OFS_DRV_STAT   = 8'h28;

	// ------------------------------------------------------------
	// Function codes
	// ------------------------------------------------------------
	localparam logic [13:0] CD_LOW    = 14'h0000;
	localparam logic [13:0] CD_MID    = 14'h0001;
	localparam logic [13:0] CD_HIGH   = 14'h0002;
	localparam logic [13:0] CD_SECOND = 14'h0003;
	localparam logic [13:0] CD_ALTCUR = 14'h0004;
	localparam logic [13:0] CD_INCH   = 14'h0005;
	localparam logic [13:0] CD_THERM  = 14'h0007;
	localparam logic [13:0] CD_REX    = 14'h0008;
	localparam logic [13:0] CD_PERMIT = 14'h000a;
	localparam logic [13:0] CD_INTLK  = 14'h000c;
	localparam logic [13:0] CD_PID    = 14'h000e;
	localparam logic [13:0] CD_PEXT   = 14'h0010;
	localparam logic [13:0] CD_VF     = 14'h0012;
	localparam logic [13:0] CD_INHIB  = 14'h0018;
	localparam logic [13:0] CD_HOLD   = 14'h0019;
	localparam logic [13:0] CD_FWD    = 14'h003c;
	localparam logic [13:0] CD_REV    = 14'h003d;
	localparam logic [13:0] CD_CLEAR  = 14'h003e;
	localparam logic [13:0] CD_PCOMM  = 14'h0041;
	localparam logic [13:0] CD_ECOMM  = 14'h0042;
	localparam logic [13:0] CD_CMDSRC = 14'h0043;
	localparam logic [13:0] CD_NONE   = 14'h270f;

	// ------------------------------------------------------------
	// Reset values and setting encodings
	// ------------------------------------------------------------
	localparam logic [13:0] FWD_SEL_RST   = CD_FWD;
	localparam logic [13:0] REV_SEL_RST   = CD_REV;
	localparam logic [13:0] LOW_SEL_RST   = CD_LOW;
	localparam logic [13:0] MID_SEL_RST   = CD_MID;
	localparam logic [13:0] HIGH_SEL_RST  = CD_HIGH;
	localparam int          TERM_FWD      = 0;
	localparam int          TERM_REV      = 1;
	localparam logic [2:0]  POL_NO        = 3'h0;
	localparam logic [2:0]  POL_NC        = 3'h2;
	localparam logic [2:0]  POL_NC_TERM   = 3'h4;
	localparam logic [7:0]  REMOTE_RST    = 8'h00;
	localparam logic [7:0]  OPMODE_RST    = 8'h00;
	localparam logic [7:0]  OPMODE_INTLK  = 8'h07;

	// ------------------------------------------------------------
	// Function vector bit positions
	// ------------------------------------------------------------
	localparam int FN_FWD = 0;
	localparam int FN_REV = 1;
	localparam int FN_LOW = 2;
	localparam int FN_MID = 3;
	localparam int FN_HIGH = 4;
	localparam int FN_RCLR = 5;
	localparam int FN_RDEC = 6;
	localparam int FN_RACC = 7;
	localparam int FN_SECOND = 8;
	localparam int FN_ALTCUR = 9;
	localparam int FN_VOLTOK = 10;
	localparam int FN_INCH = 11;
	localparam int FN_THERM = 12;
	localparam int FN_REX = 13;
	localparam int FN_PERMIT = 14;
	localparam int FN_INTLK = 15;
	localparam int FN_PID = 16;
	localparam int FN_PEXT = 17;
	localparam int FN_VF = 18;
	localparam int FN_INHIB = 19;
	localparam int FN_CLEAR = 20;
	localparam int FN_HOLD = 21;
	localparam int FN_PCOMM = 22;
	localparam int FN_ECOMM = 23;
	localparam int FN_CMDSRC = 24;
	localparam int FN_W = 25;

	localparam logic [1:0]  SRC_ANALOG = 2'h0;
	localparam logic [1:0]  SRC_INCH   = 2'h1;
	localparam logic [1:0]  SRC_PRESET = 2'h2;
	localparam logic [1:0]  SRC_PID    = 2'h3;

	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	localparam logic [1:0]  RESP_DECERR = 2'h3;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_RUN   = 3'b010,
		ST_DECEL = 3'b100
	} itr_drv_state_t;

	// Selection code accepted on a given terminal
	function automatic logic code_ok(input logic [13:0] c, input int term);
		logic ok;
		ok = (c <= CD_INCH) || (c == CD_THERM) || (c == CD_REX) || (c == CD_PERMIT)
			|| (c == CD_INTLK) || (c == CD_PID) || (c == CD_PEXT) || (c == CD_VF)
			|| (c == CD_INHIB) || (c == CD_HOLD) || (c == CD_CLEAR)
			|| (c >= CD_PCOMM && c <= CD_CMDSRC) || (c == CD_NONE);
		if (c == CD_FWD)
			ok = (term == TERM_FWD);
		if (c == CD_REV)
			ok = (term == TERM_REV);
		return ok;
	endfunction : code_ok

endpackage : itr_pkg

// >>> logic/itr_in_filter.sv
module itr_in_filter
	import itr_pkg::*;
#(
	parameter int FILTER_CYC_P = FILTER_CYC,
	parameter int CNT_W        = 18
) (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Terminal pin
	input  wire logic pin_in,
	// Filtered levels
	output logic      fast_out,
	output logic      slow_out
);

	typedef struct packed {
		logic             s1;
		logic             s2;
		logic             s3;
		logic             fast;
		logic             slow;
		logic [CNT_W-1:0] cnt;
	} itr_flt_state_t;

	itr_flt_state_t q;
	itr_flt_state_t d;

	if (FILTER_CYC_P < 1 || FILTER_CYC_P + SYNC_CYC > SLOW_CYC
		|| FILTER_CYC_P >= (1 << CNT_W)) begin : g_bad_filter
		$error("itr_in_filter: FILTER_CYC_P out of range");
	end

	always_comb begin
		d = q;
		d.s1 = pin_in;
		d.s2 = q.s1;
		d.s3 = q.s2;
		if (q.s2 == q.s3)
			d.fast = q.s3;
		// Slow path needs the level stable for the whole filter time
		if (q.s2 != q.s3 || q.s3 == q.slow) begin
			d.cnt = '0;
		end else if (q.cnt == CNT_W'(FILTER_CYC_P - 1)) begin
			d.slow = q.s3;
			d.cnt = '0;
		end else begin
			d.cnt = q.cnt + CNT_W'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			q <= '0;
		else
			q <= d;
	end

	assign fast_out = q.fast;
	assign slow_out = q.slow;

endmodule : itr_in_filter

// >>> logic/itr_router.sv
module itr_router
	import itr_pkg::*;
#(
	parameter int ADDR_W       = 8,
	parameter int FILTER_CYC_P = FILTER_CYC
) (
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite write address and data
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Input terminals and drive feedback
	input  wire logic [4:0]        term_pin,
	input  wire logic              decel_done,
	// Mapped functions
	output logic                   fwd_run_cmd,
	output logic                   rev_run_cmd,
	output logic                   low_speed_cmd,
	output logic                   mid_speed_cmd,
	output logic                   high_speed_cmd,
	output logic                   remote_clear,
	output logic                   remote_decel,
	output logic                   remote_accel,
	output logic                   second_set_select,
	output logic                   alt_current_input_sel,
	output logic                   voltage_input_valid,
	output logic                   inching_sel,
	output logic                   thermal_trip_in,
	output logic                   speed_extend_sel,
	output logic                   run_permit,
	output logic                   panel_interlock,
	output logic                   pid_enable,
	output logic                   panel_ext_switch,
	output logic                   vf_mode_switch,
	output logic                   output_inhibit,
	output logic                   drive_clear_request,
	output logic                   self_hold_sel,
	output logic                   panel_comm_switch,
	output logic                   ext_comm_switch,
	output logic                   cmd_source_switch,
	output logic [1:0]             speed_source,
	// Drive output gating
	output logic                   drive_out_en,
	output logic                   decel_req
);

	typedef struct packed {
		logic                       aw_ok;
		logic [7:0]                 awaddr;
		logic                       w_ok;
		logic [31:0]                wdata;
		logic [3:0]                 wstrb;
		logic                       bvalid;
		logic [1:0]                 bresp;
		logic                       rvalid;
		logic [31:0]                rdata;
		logic [1:0]                 rresp;
		logic [NUM_TERM-1:0][13:0]  sel;
		logic [2:0]                 pol;
		logic [7:0]                 rmode;
		logic [7:0]                 opmode;
		logic                       comm_inh;
		logic                       vf;
		itr_drv_state_t             state;
		logic [FN_W-1:0]            fn;
		logic [1:0]                 spd;
	} itr_state_t;

	itr_state_t q;
	itr_state_t d;

	logic [NUM_TERM-1:0] fast_lvl;
	logic [NUM_TERM-1:0] slow_lvl;

	if (ADDR_W < 8) begin : g_bad_addr
		$error("itr_router: ADDR_W below 8");
	end

	// ------------------------------------------------------------
	// Terminal synchronisers and filters
	// ------------------------------------------------------------
	for (genvar t = 0; t < NUM_TERM; t++) begin : g_term
		itr_in_filter #(
			.FILTER_CYC_P (FILTER_CYC_P)
		) u_flt (
			.aclk     (aclk),
			.aresetn  (aresetn),
			.pin_in   (term_pin[t]),
			.fast_out (fast_lvl[t]),
			.slow_out (slow_lvl[t])
		);
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic hit(input logic [NUM_TERM-1:0][13:0] s,
		input logic [NUM_TERM-1:0] l, input logic [13:0] c);
		logic r;
		r = 1'b0;
		for (int i = 0; i < NUM_TERM; i++)
			r = r | (s[i] == c && l[i]);
		return r;
	endfunction : hit

	function automatic logic assigned(input logic [NUM_TERM-1:0][13:0] s,
		input logic [13:0] c);
		return hit(s, {NUM_TERM{1'b1}}, c);
	endfunction : assigned

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		for (int b = 0; b < 4; b++)
			r[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
		return r;
	endfunction : merge

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	logic        ainh_t;
	logic        en;
	logic        inh;
	logic        permit;
	logic        run_cmd;
	logic        go;
	logic        preset;
	logic [31:0] wv;
	logic [31:0] old;
	logic [3:0]  widx;

	always_comb begin
		d = q;
		wv = '0;
		old = '0;
		widx = '0;

		// Inhibit and permit use the fast path
		ainh_t = hit(q.sel, fast_lvl, CD_INHIB);
		case (q.pol)
			POL_NC:      en = ainh_t && q.comm_inh;
			POL_NC_TERM: en = ainh_t && !q.comm_inh;
			default:     en = !ainh_t && !q.comm_inh;
		endcase
		inh = !en;
		if (assigned(q.sel, CD_PERMIT))
			permit = hit(q.sel, fast_lvl, CD_PERMIT);
		else
			permit = !inh;

		d.fn = '0;
		d.fn[FN_FWD] = hit(q.sel, slow_lvl, CD_FWD);
		d.fn[FN_REV] = hit(q.sel, slow_lvl, CD_REV);
		if (q.rmode == REMOTE_RST) begin
			d.fn[FN_LOW] = hit(q.sel, slow_lvl, CD_LOW);
			d.fn[FN_MID] = hit(q.sel, slow_lvl, CD_MID);
			d.fn[FN_HIGH] = hit(q.sel, slow_lvl, CD_HIGH);
		end else begin
			d.fn[FN_RCLR] = hit(q.sel, slow_lvl, CD_LOW);
			d.fn[FN_RDEC] = hit(q.sel, slow_lvl, CD_MID);
			d.fn[FN_RACC] = hit(q.sel, slow_lvl, CD_HIGH);
		end
		d.fn[FN_ALTCUR] = hit(q.sel, slow_lvl, CD_ALTCUR);
		d.fn[FN_VOLTOK] = !d.fn[FN_ALTCUR];
		d.fn[FN_INCH] = hit(q.sel, slow_lvl, CD_INCH);
		d.fn[FN_THERM] = hit(q.sel, ~slow_lvl, CD_THERM);
		d.fn[FN_REX] = hit(q.sel, slow_lvl, CD_REX);
		d.fn[FN_PERMIT] = permit;
		if (assigned(q.sel, CD_INTLK))
			d.fn[FN_INTLK] = hit(q.sel, slow_lvl, CD_INTLK);
		else
			d.fn[FN_INTLK] = (q.opmode == OPMODE_INTLK) && inh;
		d.fn[FN_PID] = hit(q.sel, slow_lvl, CD_PID);
		d.fn[FN_PEXT] = hit(q.sel, slow_lvl, CD_PEXT);
		d.fn[FN_PCOMM] = hit(q.sel, slow_lvl, CD_PCOMM);
		d.fn[FN_ECOMM] = hit(q.sel, slow_lvl, CD_ECOMM);
		d.fn[FN_CMDSRC] = hit(q.sel, slow_lvl, CD_CMDSRC);
		d.fn[FN_INHIB] = inh;
		d.fn[FN_CLEAR] = hit(q.sel, slow_lvl, CD_CLEAR);
		d.fn[FN_HOLD] = hit(q.sel, slow_lvl, CD_HOLD);

		// Control method changes only while stopped
		if (q.state == ST_IDLE)
			d.vf = hit(q.sel, slow_lvl, CD_VF);
		d.fn[FN_VF] = q.vf;
		d.fn[FN_SECOND] = hit(q.sel, slow_lvl, CD_SECOND) || hit(q.sel, slow_lvl, CD_VF);

		preset = d.fn[FN_LOW] || d.fn[FN_MID] || d.fn[FN_HIGH] || d.fn[FN_REX];
		if (d.fn[FN_INCH])
			d.spd = SRC_INCH;
		else if (preset)
			d.spd = SRC_PRESET;
		else if (d.fn[FN_PID])
			d.spd = SRC_PID;
		else
			d.spd = SRC_ANALOG;

		// Drive sequencing
		run_cmd = q.fn[FN_FWD] ^ q.fn[FN_REV];
		go = run_cmd && permit && !inh;
		case (q.state)
			ST_IDLE: begin
				if (go)
					d.state = ST_RUN;
			end
			ST_RUN: begin
				if (inh || !permit)
					d.state = ST_IDLE;
				else if (!run_cmd)
					d.state = ST_DECEL;
			end
			ST_DECEL: begin
				if (inh || !permit || decel_done)
					d.state = ST_IDLE;
				else if (go)
					d.state = ST_RUN;
			end
			default: d.state = ST_IDLE;
		endcase

		// ------------------------------------------------------------
		// AXI4-Lite write
		// ------------------------------------------------------------
		if (s_axi_awvalid && !q.aw_ok) begin
			d.aw_ok = 1'b1;
			d.awaddr = s_axi_awaddr[7:0];
		end
		if (s_axi_wvalid && !q.w_ok) begin
			d.w_ok = 1'b1;
			d.wdata = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
		end
		if (q.bvalid && s_axi_bready)
			d.bvalid = 1'b0;
		if (q.aw_ok && q.w_ok && !q.bvalid) begin
			d.aw_ok = 1'b0;
			d.w_ok = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = RESP_OKAY;
			widx = q.awaddr[5:2];
			if (q.awaddr[7:6] != 2'h0 || q.awaddr > OFS_DRV_STAT
				|| q.awaddr[1:0] != 2'h0) begin
				d.bresp = RESP_DECERR;
			end else if (q.awaddr <= OFS_HIGH_SEL) begin
				old = {18'h0, q.sel[widx]};
				wv = merge(old, q.wdata, q.wstrb);
				if (wv[31:14] == '0 && code_ok(wv[13:0], int'(widx)))
					d.sel[widx] = wv[13:0];
				else
					d.bresp = RESP_SLVERR;
			end else if (q.awaddr == OFS_POLARITY) begin
				wv = merge({29'h0, q.pol}, q.wdata, q.wstrb);
				if (wv == 32'(POL_NO) || wv == 32'(POL_NC) || wv == 32'(POL_NC_TERM))
					d.pol = wv[2:0];
				else
					d.bresp = RESP_SLVERR;
			end else if (q.awaddr == OFS_REMOTE) begin
				wv = merge({24'h0, q.rmode}, q.wdata, q.wstrb);
				d.rmode = wv[7:0];
			end else if (q.awaddr == OFS_OPMODE) begin
				wv = merge({24'h0, q.opmode}, q.wdata, q.wstrb);
				d.opmode = wv[7:0];
			end else if (q.awaddr == OFS_CTRL) begin
				wv = merge({31'h0, q.comm_inh}, q.wdata, q.wstrb);
				d.comm_inh = wv[0];
			end else begin
				d.bresp = RESP_SLVERR;
			end
		end

		// ------------------------------------------------------------
		// AXI4-Lite read
		// ------------------------------------------------------------
		if (q.rvalid && s_axi_rready)
			d.rvalid = 1'b0;
		if (s_axi_arvalid && !q.rvalid) begin
			d.rvalid = 1'b1;
			d.rresp = RESP_OKAY;
			d.rdata = '0;
			if (s_axi_araddr[7:0] <= OFS_HIGH_SEL)
				d.rdata = {18'h0, q.sel[s_axi_araddr[5:2]]};
			else if (s_axi_araddr[7:0] == OFS_POLARITY)
				d.rdata = {29'h0, q.pol};
			else if (s_axi_araddr[7:0] == OFS_REMOTE)
				d.rdata = {24'h0, q.rmode};
			else if (s_axi_araddr[7:0] == OFS_OPMODE)
				d.rdata = {24'h0, q.opmode};
			else if (s_axi_araddr[7:0] == OFS_CTRL)
				d.rdata = {31'h0, q.comm_inh};
			else if (s_axi_araddr[7:0] == OFS_FUNC_STAT)
				d.rdata = {7'h0, q.fn};
			else if (s_axi_araddr[7:0] == OFS_DRV_STAT)
				d.rdata = {26'h0, q.vf, q.spd, q.state};
			else
				d.rresp = RESP_DECERR;
			if (s_axi_araddr[1:0] != 2'h0 || (s_axi_araddr >> 8) != '0) begin
				d.rdata = '0;
				d.rresp = RESP_DECERR;
			end
		end
		if (s_axi_awvalid && !q.aw_ok && (s_axi_awaddr >> 8) != '0)
			d.awaddr = 8'hff;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.sel[0] <= FWD_SEL_RST;
			q.sel[1] <= REV_SEL_RST;
			q.sel[2] <= LOW_SEL_RST;
			q.sel[3] <= MID_SEL_RST;
			q.sel[4] <= HIGH_SEL_RST;
			q.pol <= POL_NO;
			q.rmode <= REMOTE_RST;
			q.opmode <= OPMODE_RST;
			q.state <= ST_IDLE;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign s_axi_awready         = !q.aw_ok;
	assign s_axi_wready          = !q.w_ok;
	assign s_axi_bvalid          = q.bvalid;
	assign s_axi_bresp           = q.bresp;
	assign s_axi_arready         = !q.rvalid;
	assign s_axi_rvalid          = q.rvalid;
	assign s_axi_rdata           = q.rdata;
	assign s_axi_rresp           = q.rresp;
	assign fwd_run_cmd           = q.fn[FN_FWD];
	assign rev_run_cmd           = q.fn[FN_REV];
	assign low_speed_cmd         = q.fn[FN_LOW];
	assign mid_speed_cmd         = q.fn[FN_MID];
	assign high_speed_cmd        = q.fn[FN_HIGH];
	assign remote_clear          = q.fn[FN_RCLR];
	assign remote_decel          = q.fn[FN_RDEC];
	assign remote_accel          = q.fn[FN_RACC];
	assign second_set_select     = q.fn[FN_SECOND];
	assign alt_current_input_sel = q.fn[FN_ALTCUR];
	assign voltage_input_valid   = q.fn[FN_VOLTOK];
	assign inching_sel           = q.fn[FN_INCH];
	assign thermal_trip_in       = q.fn[FN_THERM];
	assign speed_extend_sel      = q.fn[FN_REX];
	assign run_permit            = q.fn[FN_PERMIT];
	assign panel_interlock       = q.fn[FN_INTLK];
	assign pid_enable            = q.fn[FN_PID];
	assign panel_ext_switch      = q.fn[FN_PEXT];
	assign vf_mode_switch        = q.fn[FN_VF];
	assign output_inhibit        = q.fn[FN_INHIB];
	assign drive_clear_request   = q.fn[FN_CLEAR];
	assign self_hold_sel         = q.fn[FN_HOLD];
	assign panel_comm_switch     = q.fn[FN_PCOMM];
	assign ext_comm_switch       = q.fn[FN_ECOMM];
	assign cmd_source_switch     = q.fn[FN_CMDSRC];
	assign speed_source          = q.spd;
	assign drive_out_en          = q.state != ST_IDLE;
	assign decel_req             = q.state == ST_DECEL;

endmodule : itr_router

// >>> tb/itr_router_properties.sv
module itr_router_chk
	import itr_pkg::*;
(
	// Clock and reset
	input wire logic       aclk,
	input wire logic       aresetn,
	// Watched outputs
	input wire logic       fwd_run_cmd,
	input wire logic       rev_run_cmd,
	input wire logic       low_speed_cmd,
	input wire logic       mid_speed_cmd,
	input wire logic       high_speed_cmd,
	input wire logic       remote_clear,
	input wire logic       remote_decel,
	input wire logic       remote_accel,
	input wire logic       alt_current_input_sel,
	input wire logic       voltage_input_valid,
	input wire logic       inching_sel,
	input wire logic       run_permit,
	input wire logic       output_inhibit,
	input wire logic [1:0] speed_source,
	input wire logic       drive_out_en,
	input wire logic       decel_req
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_volt; alt_current_input_sel |-> !voltage_input_valid; endproperty
	a_volt: assert property (p_volt) else $error("voltage input left valid");
	property p_cut; output_inhibit |-> ##[0:2] !drive_out_en; endproperty
	a_cut: assert property (p_cut) else $error("inhibit did not cut output");
	property p_hold; output_inhibit [*3] |-> !drive_out_en; endproperty
	a_hold: assert property (p_hold) else $error("output on under inhibit");
	property p_start; $rose(drive_out_en) |-> run_permit && (fwd_run_cmd ^ rev_run_cmd);
	endproperty
	a_start: assert property (p_start) else $error("start without permit");
	property p_dec; decel_req |-> drive_out_en; endproperty
	a_dec: assert property (p_dec) else $error("ramp without output");
	property p_stop; drive_out_en && !decel_req && !output_inhibit && run_permit
		##1 !(fwd_run_cmd ^ rev_run_cmd) && !output_inhibit && run_permit
		|-> ##[0:2] decel_req; endproperty
	a_stop: assert property (p_stop) else $error("stop did not ramp");
	property p_inch; inching_sel [*2] |-> speed_source == SRC_INCH; endproperty
	a_inch: assert property (p_inch) else $error("inching not first");
	property p_pre; (!inching_sel && (low_speed_cmd || mid_speed_cmd || high_speed_cmd)) [*2]
		|-> speed_source == SRC_PRESET; endproperty
	a_pre: assert property (p_pre) else $error("preset not before pid");
	property p_rem; remote_clear || remote_decel || remote_accel
		|-> !(low_speed_cmd || mid_speed_cmd || high_speed_cmd); endproperty
	a_rem: assert property (p_rem) else $error("speed and remote together");
endmodule : itr_router_chk

bind itr_router itr_router_chk u_chk (.*);

// >>> tb/itr_contacts.sv
module itr_contacts (
	// Commanded contact state
	input  wire logic [4:0] closed,
	// Terminal pins
	output logic      [4:0] term_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] diff;
	initial term_pin = 5'h00;
	// Contacts chatter before they settle
	always @(closed) begin
		diff = closed ^ term_pin;
		repeat (3) begin
			#13 term_pin = term_pin ^ diff;
		end
		#13 term_pin = closed;
	end
endmodule : itr_contacts

// >>> tb/testbench.sv
module testbench
	import itr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk, aresetn, decel_done, en;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [2:0] p;
	logic [1:0] s_axi_bresp, s_axi_rresp, speed_source;
	logic [4:0] closed, term_pin;
	logic fwd_run_cmd, rev_run_cmd, low_speed_cmd, mid_speed_cmd, high_speed_cmd;
	logic remote_clear, remote_decel, remote_accel, second_set_select, inching_sel;
	logic alt_current_input_sel, voltage_input_valid, thermal_trip_in, speed_extend_sel;
	logic run_permit, panel_interlock, pid_enable, panel_ext_switch, vf_mode_switch;
	logic output_inhibit, drive_clear_request, self_hold_sel, panel_comm_switch;
	logic ext_comm_switch, cmd_source_switch, drive_out_en, decel_req;
	logic [31:0] rst [6] = '{32'h3c, 32'h3d, 32'h0, 32'h1, 32'h2, 32'h0};
	int mismatches, num_checks, i;
	itr_router #(.FILTER_CYC_P(4)) u_dut (.*);
	itr_contacts u_sw (.closed(closed), .term_pin(term_pin));
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic chkb(input string n, input logic e, input logic g);
		chk(n, {31'h0, e}, {31'h0, g});
	endtask : chkb
	task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic aw;
		logic w;
		aw = 1'b1;
		w = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (aw || w) begin
			@(posedge aclk);
			aw = aw && !s_axi_awready;
			w = w && !s_axi_wready;
			s_axi_awvalid <= aw;
			s_axi_wvalid <= w;
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		chk("bresp", {30'h0, e}, {30'h0, s_axi_bresp});
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask : wrc
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		chk("rdata", e, s_axi_rdata);
		chk("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : rdc
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		{aresetn, decel_done, closed, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (i = 0; i < 6; i++) rdc(8'(4 * i), rst[i], RESP_OKAY);
		rdc(8'h2c, 32'h0, RESP_DECERR);
		wrc(OFS_REV_SEL, 32'h3c, RESP_SLVERR);
		wrc(OFS_FWD_SEL, 32'h3d, RESP_SLVERR);
		wrc(OFS_LOW_SEL, 32'h06, RESP_SLVERR);
		wrc(OFS_POLARITY, 32'h01, RESP_SLVERR);
		rdc(OFS_LOW_SEL, 32'h0, RESP_OKAY);
		wrc(OFS_LOW_SEL, 32'h270f, RESP_OKAY);
		$display("test settings done");
		closed[0] <= 1'b1;
		repeat (30) @(posedge aclk);
		chkb("drive_on", 1'b1, drive_out_en);
		wrc(OFS_LOW_SEL, 32'h18, RESP_OKAY);
		closed[2] <= 1'b1;
		repeat (10) @(posedge aclk);
		chkb("inhibit", 1'b1, output_inhibit);
		chkb("coast", 1'b0, drive_out_en);
		chkb("no_ramp", 1'b0, decel_req);
		chkb("permit", 1'b0, run_permit);
		closed[2] <= 1'b0;
		repeat (10) @(posedge aclk);
		chkb("restart", 1'b1, drive_out_en);
		closed[0] <= 1'b0;
		repeat (30) @(posedge aclk);
		chkb("ramp", 1'b1, decel_req & drive_out_en);
		decel_done <= 1'b1;
		repeat (3) @(posedge aclk);
		chkb("stopped", 1'b0, drive_out_en);
		decel_done <= 1'b0;
		$display("test drive done");
		for (i = 0; i < 12; i++) begin
			p = 3'(2 * (i / 4));
			wrc(OFS_POLARITY, {29'h0, p}, RESP_OKAY);
			wrc(OFS_CTRL, {31'h0, i[0]}, RESP_OKAY);
			closed[2] <= i[1];
			repeat (10) @(posedge aclk);
			en = (p == POL_NO) ? !i[1] && !i[0] : (p == POL_NC) ? i[1] && i[0] : i[1] && !i[0];
			chkb("inhibit_pol", !en, output_inhibit);
		end
		$display("test polarity done");
		wrc(OFS_LOW_SEL, 32'h05, RESP_OKAY);
		wrc(OFS_MID_SEL, 32'h03, RESP_OKAY);
		wrc(OFS_REV_SEL, 32'h03, RESP_OKAY);
		closed <= 5'h16;
		repeat (30) @(posedge aclk);
		chkb("second_or", 1'b1, second_set_select);
		chkb("high", 1'b1, high_speed_cmd);
		chk("src_inch", {30'h0, SRC_INCH}, {30'h0, speed_source});
		closed <= 5'h10;
		repeat (30) @(posedge aclk);
		chk("src_preset", {30'h0, SRC_PRESET}, {30'h0, speed_source});
		chkb("second_off", 1'b0, second_set_select);
		wrc(OFS_REMOTE, 32'h01, RESP_OKAY);
		wrc(OFS_MID_SEL, 32'h04, RESP_OKAY);
		wrc(OFS_FWD_SEL, 32'h07, RESP_OKAY);
		closed <= 5'h18;
		repeat (30) @(posedge aclk);
		chkb("accel", 1'b1, remote_accel);
		chkb("high_off", 1'b0, high_speed_cmd);
		chkb("volt", 1'b0, voltage_input_valid);
		chkb("thermal", 1'b1, thermal_trip_in);
		wrc(OFS_FWD_SEL, 32'h19, RESP_OKAY);
		wrc(OFS_REV_SEL, 32'h3e, RESP_OKAY);
		wrc(OFS_LOW_SEL, 32'h08, RESP_OKAY);
		wrc(OFS_MID_SEL, 32'h12, RESP_OKAY);
		wrc(OFS_HIGH_SEL, 32'h0e, RESP_OKAY);
		wrc(OFS_OPMODE, 32'h07, RESP_OKAY);
		wrc(8'h01, 32'h3c, RESP_DECERR);
		closed <= 5'h1f;
		repeat (30) @(posedge aclk);
		chkb("hold", 1'b1, self_hold_sel);
		chkb("clear", 1'b1, drive_clear_request);
		chkb("vf", 1'b1, vf_mode_switch & second_set_select);
		chk("src_rex", {30'h0, SRC_PRESET}, {30'h0, speed_source});
		chkb("intlk", 1'b1, panel_interlock & pid_enable);
		$display("test mapping done");
		tally_and_finish();
	end
	initial begin
		repeat (20000) @(posedge aclk);
		mismatches++;
		tally_and_finish();
	end
endmodule : testbench
